// >>> src/art_params.svh
// Register offsets, field positions, reset values and timing counts of the reload timer
`ifndef ART_PARAMS_SVH
`define ART_PARAMS_SVH

// Register indices; byte address is four times the index
`define ART_IDX_CSR        6'h0d
`define ART_IDX_CNT_HI     6'h0e
`define ART_IDX_CNT_LO     6'h0f
`define ART_IDX_RLD_HI     6'h10
`define ART_IDX_RLD_LO     6'h11
`define ART_IDX_CAP_HI     6'h1f
`define ART_IDX_CAP_LO     6'h20
`define ART_IDX_EVT_STAT   6'h30
`define ART_IDX_EVT_MASK   6'h31

// Control/status field positions
`define ART_CSR_CAPF       6
`define ART_CSR_CAPIE      5
`define ART_CSR_SEL_HI     4
`define ART_CSR_SEL_LO     3
`define ART_CSR_WRAPF      2
`define ART_CSR_WRAPIE     1
`define ART_CSR_COMPARE_IRQ_ENABLE      0

// Event status and mask field positions
`define ART_EVT_CAP        0
`define ART_EVT_WRAP       1
`define ART_EVT_CMP        2
`define ART_EVT_W          3

// Widths and reset values
`define ART_CNT_W          12
`define ART_CNT_MAX        12'hfff
`define ART_CNT_RST        12'h000
`define ART_RLD_RST        12'h000
`define ART_CMP_N          4

// Bus answers
`define ART_RESP_OKAY      2'b00
`define ART_RESP_SLVERR    2'b10

// Timing: clock rates in MHz and the lite tick period in microseconds
`define ART_MCLK_MHZ       40
`define ART_FAST_MHZ       32
`define ART_CPU_MHZ        8
`define ART_LITE_PERIOD_US 1000
`define ART_LITE_CYCLES    (`ART_LITE_PERIOD_US * `ART_MCLK_MHZ)

`endif

// >>> src/art_pkg.sv
// Types shared by the reload timer files
package art_pkg;

   typedef enum logic [1:0] {
      ART_SEL_OFF  = 2'b00,
      ART_SEL_LITE = 2'b01,
      ART_SEL_CPU  = 2'b10,
      ART_SEL_FAST = 2'b11
   } art_clksel_t;

endpackage

// >>> src/art_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module art_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_r;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule // art_sync

// >>> src/art_tick.sv
// Fractional tick generator: STEP ticks every MODULUS clock cycles
`timescale 1ns/1ps
module art_tick #(
   parameter logic [15:0] STEP    = 16'h0001,
   parameter logic [15:0] MODULUS = 16'h0001
) (
   input  wire logic mclk,
   input  wire logic nrst,
   output logic      tick
);

   logic [16:0] acc_r;
   logic [16:0] sum;

   assign sum = acc_r + {1'b0, STEP};

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         acc_r <= 17'h00000;
         tick  <= 1'b0;
      end else if (sum >= {1'b0, MODULUS}) begin
         acc_r <= sum - {1'b0, MODULUS};
         tick  <= 1'b1;
      end else begin
         acc_r <= sum;
         tick  <= 1'b0;
      end
   end

endmodule // art_tick

// >>> src/art_timer.sv
// Auto-reload 12-bit timer with input capture and an AXI4-Lite register slave
//
// What this block does
// - An edge on the capture pin while the capture flag is clear copies the 12-bit count into the capture register.
// - Each accepted capture sets the capture flag in the control/status register.
// - Capture interrupt request is high while capture flag and its enable are set.
// - Reading capture high or low byte while the flag is set clears it.
// - While the capture flag is set, further edges are ignored.
// - Capture register is read-only and holds the latest accepted capture.
// - Software writes never change the capture flag.
// - Clock select: 00 off, 01 lite tick, 10 CPU clock, 11 32 MHz.
// - Wrap flag sets when the count passes from FFFh to the reload value.
// - Reading the control/status register clears the wrap flag.
// - Wrap interrupt enable is read/write, resets to zero, gates the wrap request.
// - Compare interrupt enable masks the request from any compare flag.
// - Counter increments on every tick of the selected count clock.
// - On wrap the counter restarts from the reload register value.
// - Counter, clock select and enables are read-only or cleared at reset.
// - Counter high bits 15:12 and control bit 7 read as zero.
`timescale 1ns/1ps
`include "art_params.svh"
module art_timer #(
   parameter logic [15:0] LITE_TICK_CYCLES = 16'(`ART_LITE_CYCLES)
) (
   input  wire logic                   mclk,
   input  wire logic                   nrst,
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic                   capture_input_pin,
   input  wire logic [`ART_CMP_N-1:0]  compare_flags,
   output logic                        irq_capture,
   output logic                        irq_wrap,
   output logic                        irq_compare,
   output logic                        irq
);

   logic [`ART_CNT_W-1:0] free_run_count_r;
   logic [`ART_CNT_W-1:0] reload_value_r;
   logic [`ART_CNT_W-1:0] capture_value_r;
   logic                  capture_flag_r;
   logic                  capture_irq_enable_r;
   art_pkg::art_clksel_t  count_clock_select_r;
   logic                  wrap_flag_r;
   logic                  wrap_irq_enable_r;
   logic                  compare_irq_enable_r;
   logic [`ART_EVT_W-1:0] evt_status_r;
   logic [`ART_EVT_W-1:0] evt_mask_r;
   logic                  cmp_req_d_r;

   logic                  fast_tick;
   logic                  cpu_tick;
   logic                  lite_tick_clock;
   logic                  count_tick;
   logic                  cap_sync;
   logic                  cap_prev_r;
   logic                  cap_edge;
   logic                  cap_take;
   logic                  wrap_evt;
   logic                  cmp_req;

   logic                  aw_full_r;
   logic                  w_full_r;
   logic [5:0]            wr_idx_r;
   logic                  wr_lane_r;
   logic [7:0]            wr_byte_r;
   logic [1:0]            wr_low_r;
   logic                  wr_do;
   logic                  wr_map;
   logic                  rd_take;
   logic [5:0]            rd_idx;
   logic                  rd_map;
   logic [7:0]            rd_byte;

   // Tick sources derived from mclk
   art_tick #(
      .STEP    (16'(`ART_FAST_MHZ)),
      .MODULUS (16'(`ART_MCLK_MHZ))
   ) u_fast_tick (
      .mclk (mclk),
      .nrst (nrst),
      .tick (fast_tick)
   );

   art_tick #(
      .STEP    (16'(`ART_CPU_MHZ)),
      .MODULUS (16'(`ART_MCLK_MHZ))
   ) u_cpu_tick (
      .mclk (mclk),
      .nrst (nrst),
      .tick (cpu_tick)
   );

   art_tick #(
      .STEP    (16'h0001),
      .MODULUS (LITE_TICK_CYCLES)
   ) u_lite_tick (
      .mclk (mclk),
      .nrst (nrst),
      .tick (lite_tick_clock)
   );

   always_comb begin
      case (count_clock_select_r)
         art_pkg::ART_SEL_OFF:  count_tick = 1'b0;
         art_pkg::ART_SEL_LITE: count_tick = lite_tick_clock;
         art_pkg::ART_SEL_CPU:  count_tick = cpu_tick;
         art_pkg::ART_SEL_FAST: count_tick = fast_tick;
         default:               count_tick = 1'b0;
      endcase
   end

   assign wrap_evt = count_tick && (free_run_count_r == `ART_CNT_MAX);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         free_run_count_r <= `ART_CNT_RST;
      end else if (wrap_evt) begin
         free_run_count_r <= reload_value_r;
      end else if (count_tick) begin
         free_run_count_r <= free_run_count_r + 12'h001;
      end
   end

   art_sync #(
      .W (1)
   ) u_cap_sync (
      .mclk     (mclk),
      .nrst     (nrst),
      .async_in (capture_input_pin),
      .sync_out (cap_sync)
   );

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cap_prev_r <= 1'b0;
      end else begin
         cap_prev_r <= cap_sync;
      end
   end

   assign cap_edge = cap_sync ^ cap_prev_r;
   assign cap_take = cap_edge && !capture_flag_r;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         capture_value_r <= `ART_CNT_RST;
      end else if (cap_take) begin
         capture_value_r <= free_run_count_r;
      end
   end

   // Register bus decode
   assign rd_take = s_axi_arvalid && s_axi_arready;
   assign rd_idx  = s_axi_araddr[7:2];
   assign wr_do   = aw_full_r && w_full_r && !s_axi_bvalid;

   always_comb begin
      case (rd_idx)
         `ART_IDX_CSR, `ART_IDX_CNT_HI, `ART_IDX_CNT_LO, `ART_IDX_RLD_HI,
         `ART_IDX_RLD_LO, `ART_IDX_CAP_HI, `ART_IDX_CAP_LO,
         `ART_IDX_EVT_STAT, `ART_IDX_EVT_MASK: rd_map = (s_axi_araddr[1:0] == 2'b00);
         default: rd_map = 1'b0;
      endcase
   end

   always_comb begin
      case (wr_idx_r)
         `ART_IDX_CSR, `ART_IDX_RLD_HI, `ART_IDX_RLD_LO,
         `ART_IDX_EVT_STAT, `ART_IDX_EVT_MASK: wr_map = (wr_low_r == 2'b00);
         `ART_IDX_CNT_HI, `ART_IDX_CNT_LO, `ART_IDX_CAP_HI,
         `ART_IDX_CAP_LO: wr_map = (wr_low_r == 2'b00);
         default: wr_map = 1'b0;
      endcase
   end

   always_comb begin
      case (rd_idx)
         `ART_IDX_CSR:      rd_byte = {1'b0, capture_flag_r, capture_irq_enable_r,
                                       count_clock_select_r, wrap_flag_r,
                                       wrap_irq_enable_r, compare_irq_enable_r};
         `ART_IDX_CNT_HI:   rd_byte = {4'h0, free_run_count_r[11:8]};
         `ART_IDX_CNT_LO:   rd_byte = free_run_count_r[7:0];
         `ART_IDX_RLD_HI:   rd_byte = {4'h0, reload_value_r[11:8]};
         `ART_IDX_RLD_LO:   rd_byte = reload_value_r[7:0];
         `ART_IDX_CAP_HI:   rd_byte = {4'h0, capture_value_r[11:8]};
         `ART_IDX_CAP_LO:   rd_byte = capture_value_r[7:0];
         `ART_IDX_EVT_STAT: rd_byte = {5'h00, evt_status_r};
         `ART_IDX_EVT_MASK: rd_byte = {5'h00, evt_mask_r};
         default:           rd_byte = 8'h00;
      endcase
   end

   // Write address and data channels, taken in either order
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         aw_full_r     <= 1'b0;
         wr_idx_r      <= 6'h00;
         wr_low_r      <= 2'b00;
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full_r     <= 1'b1;
         wr_idx_r      <= s_axi_awaddr[7:2];
         wr_low_r      <= s_axi_awaddr[1:0];
         s_axi_awready <= 1'b0;
      end else if (wr_do) begin
         aw_full_r     <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         w_full_r     <= 1'b0;
         wr_byte_r    <= 8'h00;
         wr_lane_r    <= 1'b0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full_r     <= 1'b1;
         wr_byte_r    <= s_axi_wdata[7:0];
         wr_lane_r    <= s_axi_wstrb[0];
         s_axi_wready <= 1'b0;
      end else if (wr_do) begin
         w_full_r     <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   // Write response
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `ART_RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_map ? `ART_RESP_OKAY : `ART_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `ART_RESP_OKAY;
      end else if (rd_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h000000, rd_byte};
         s_axi_rresp   <= rd_map ? `ART_RESP_OKAY : `ART_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end

   // Software-written control fields, cleared at reset
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         capture_irq_enable_r <= 1'b0;
         count_clock_select_r <= art_pkg::ART_SEL_OFF;
         wrap_irq_enable_r    <= 1'b0;
         compare_irq_enable_r <= 1'b0;
      end else if (wr_do && wr_lane_r && wr_map && wr_idx_r == `ART_IDX_CSR) begin
         capture_irq_enable_r <= wr_byte_r[`ART_CSR_CAPIE];
         count_clock_select_r <= art_pkg::art_clksel_t'(wr_byte_r[`ART_CSR_SEL_HI:`ART_CSR_SEL_LO]);
         wrap_irq_enable_r    <= wr_byte_r[`ART_CSR_WRAPIE];
         compare_irq_enable_r <= wr_byte_r[`ART_CSR_COMPARE_IRQ_ENABLE];
      end
   end

   // Reload register
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         reload_value_r <= `ART_RLD_RST;
      end else if (wr_do && wr_lane_r && wr_map && wr_idx_r == `ART_IDX_RLD_HI) begin
         reload_value_r[11:8] <= wr_byte_r[3:0];
      end else if (wr_do && wr_lane_r && wr_map && wr_idx_r == `ART_IDX_RLD_LO) begin
         reload_value_r[7:0] <= wr_byte_r;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         capture_flag_r <= 1'b0;
      end else if (cap_take) begin
         capture_flag_r <= 1'b1;
      end else if (rd_take && rd_map && (rd_idx == `ART_IDX_CAP_HI ||
                                         rd_idx == `ART_IDX_CAP_LO)) begin
         capture_flag_r <= 1'b0;
      end
   end

   // Wrap flag, set wins over clear
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wrap_flag_r <= 1'b0;
      end else if (wrap_evt) begin
         wrap_flag_r <= 1'b1;
      end else if (rd_take && rd_map && rd_idx == `ART_IDX_CSR) begin
         wrap_flag_r <= 1'b0;
      end
   end

   assign cmp_req = compare_irq_enable_r && (|compare_flags);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cmp_req_d_r <= 1'b0;
      end else begin
         cmp_req_d_r <= cmp_req;
      end
   end

   // Sticky event status, write one to clear, set wins
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         evt_status_r <= 3'h0;
      end else begin
         for (int i = 0; i < `ART_EVT_W; i++) begin
            if ((i == `ART_EVT_CAP && cap_take) || (i == `ART_EVT_WRAP && wrap_evt) ||
                (i == `ART_EVT_CMP && cmp_req && !cmp_req_d_r)) begin
               evt_status_r[i] <= 1'b1;
            end else if (wr_do && wr_lane_r && wr_map &&
                         wr_idx_r == `ART_IDX_EVT_STAT && wr_byte_r[i]) begin
               evt_status_r[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         evt_mask_r <= 3'h0;
      end else if (wr_do && wr_lane_r && wr_map && wr_idx_r == `ART_IDX_EVT_MASK) begin
         evt_mask_r <= wr_byte_r[`ART_EVT_W-1:0];
      end
   end

   // Interrupt outputs
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         irq_capture <= 1'b0;
         irq_wrap    <= 1'b0;
         irq_compare <= 1'b0;
         irq         <= 1'b0;
      end else begin
         irq_capture <= capture_flag_r && capture_irq_enable_r;
         irq_wrap    <= wrap_flag_r && wrap_irq_enable_r;
         irq_compare <= cmp_req;
         irq         <= |(evt_status_r & evt_mask_r);
      end
   end

endmodule // art_timer

// >>> verification/art_timer_asserts.sv
// Port-level assertions for the reload timer, bound to its top module
`timescale 1ns/1ps
`include "art_params.svh"
module art_timer_asserts (
   input wire logic                  mclk,
   input wire logic                  nrst,
   input wire logic                  s_axi_awvalid,
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wvalid,
   input wire logic                  s_axi_wready,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_bready,
   input wire logic [7:0]            s_axi_araddr,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic [31:0]           s_axi_rdata,
   input wire logic [1:0]            s_axi_rresp,
   input wire logic                  s_axi_rvalid,
   input wire logic                  s_axi_rready,
   input wire logic [`ART_CMP_N-1:0] compare_flags,
   input wire logic                  irq_capture,
   input wire logic                  irq_compare
);
   localparam logic [7:0] A_CSR    = {`ART_IDX_CSR, 2'b00};
   localparam logic [7:0] A_CNT_HI = {`ART_IDX_CNT_HI, 2'b00};
   localparam logic [7:0] A_CAP_HI = {`ART_IDX_CAP_HI, 2'b00};
   localparam logic [7:0] A_CAP_LO = {`ART_IDX_CAP_LO, 2'b00};

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence s_rd_at(logic [7:0] a);
      s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
   endsequence
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence

   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && !s_axi_arready)
      else $error("read answer not held");
   a_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_err_unmapped: assert property (s_rd_at(8'hfc) |=>
      s_axi_rresp == `ART_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_rdata_top: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_csr_bit7: assert property (s_rd_at(A_CSR) |=> !s_axi_rdata[7])
      else $error("control bit 7 reads one");
   a_cnt_hi_zero: assert property (s_rd_at(A_CNT_HI) |=> s_axi_rdata[7:4] == 4'h0)
      else $error("count high reserved bits set");
   a_cap_clear: assert property ((s_rd_at(A_CAP_LO) or s_rd_at(A_CAP_HI)) |-> ##2 !irq_capture)
      else $error("capture request survives capture read");
   a_cmp_gate: assert property (irq_compare |-> $past(|compare_flags))
      else $error("compare request without compare flag");
   a_cmp_drop: assert property (!(|compare_flags) |=> !irq_compare)
      else $error("compare request not dropped");
endmodule // art_timer_asserts

bind art_timer art_timer_asserts art_timer_asserts_i (
   .mclk          (mclk),
   .nrst          (nrst),
   .s_axi_awvalid (s_axi_awvalid),
   .s_axi_awready (s_axi_awready),
   .s_axi_wvalid  (s_axi_wvalid),
   .s_axi_wready  (s_axi_wready),
   .s_axi_bvalid  (s_axi_bvalid),
   .s_axi_bready  (s_axi_bready),
   .s_axi_araddr  (s_axi_araddr),
   .s_axi_arvalid (s_axi_arvalid),
   .s_axi_arready (s_axi_arready),
   .s_axi_rdata   (s_axi_rdata),
   .s_axi_rresp   (s_axi_rresp),
   .s_axi_rvalid  (s_axi_rvalid),
   .s_axi_rready  (s_axi_rready),
   .compare_flags (compare_flags),
   .irq_capture   (irq_capture),
   .irq_compare   (irq_compare)
);

// >>> verification/art_timer_tb_top.sv
// Self-checking register-level bench for the reload timer
`timescale 1ns/1ps
`include "art_params.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module art_timer_tb_top;
   localparam logic [1:0] OK = `ART_RESP_OKAY;
   localparam logic [1:0] ER = `ART_RESP_SLVERR;
   logic        mclk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, pin, irq_cap, irq_wrap, irq_cmp, irq;
   logic [7:0]  awaddr, araddr, d;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [3:0]  cmp_flags, strb;
   logic [11:0] c0, c1;
   int          n_fail, checked, cyc, t, dlt;

   art_timer #(.LITE_TICK_CYCLES(16'd20)) art_timer_i (
      .mclk(mclk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .capture_input_pin(pin), .compare_flags(cmp_flags), .irq_capture(irq_cap),
      .irq_wrap(irq_wrap), .irq_compare(irq_cmp), .irq(irq));

   always #12.5 mclk = ~mclk;

   task automatic close_out();
      if (n_fail == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         close_out();
      end
   end

   task automatic wr(input logic [5:0] idx, input logic [7:0] v, input logic [1:0] er);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge mclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge mclk);
         if (awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge mclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      `CHK("bresp", er, bresp)
   endtask

   task automatic rd(input logic [5:0] idx, output logic [7:0] v, input logic [1:0] er);
      @(posedge mclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      do @(posedge mclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      // Late rready makes the design hold its answer one cycle
      @(posedge mclk);
      rready <= 1'b1;
      do @(posedge mclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      v = rdata[7:0];
      `CHK("rresp", er, rresp)
   endtask

   task automatic rx(input logic [5:0] idx, input logic [7:0] e);
      logic [7:0] v;
      rd(idx, v, OK);
      `CHK($sformatf("reg %h", idx), e, v)
   endtask

   // Low byte first, counter stopped by the caller
   task automatic rd_cnt(output logic [11:0] c);
      logic [7:0] lo;
      logic [7:0] hi;
      rd(`ART_IDX_CNT_LO, lo, OK);
      rd(`ART_IDX_CNT_HI, hi, OK);
      c = {hi[3:0], lo};
   endtask

   initial begin
      {mclk, nrst, awvalid, wvalid, bready, arvalid, rready, pin} = '0;
      {awaddr, araddr, wdata, cmp_flags, n_fail, checked, cyc} = '0;
      strb = 4'hf;
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      rx(`ART_IDX_CSR, 8'h00);
      rx(`ART_IDX_CNT_HI, 8'h00);
      rx(`ART_IDX_CNT_LO, 8'h00);
      rx(`ART_IDX_EVT_MASK, 8'h00);
      `CHK("irq", 1'b0, irq)
      rd(6'h3f, d, ER);
      `CHK("unmapped", 8'h00, d)
      wr(6'h3f, 8'h11, ER);
      wr(`ART_IDX_CSR, 8'he3, OK);
      rx(`ART_IDX_CSR, 8'h23);
      wr(`ART_IDX_CNT_LO, 8'h55, OK);
      repeat (50) @(posedge mclk);
      rx(`ART_IDX_CNT_LO, 8'h00);
      wr(`ART_IDX_RLD_LO, 8'ha5, OK);
      rx(`ART_IDX_RLD_LO, 8'ha5);
      // Write without its byte lane leaves the register alone
      strb <= 4'h0;
      wr(`ART_IDX_RLD_LO, 8'h3c, OK);
      strb <= 4'hf;
      rx(`ART_IDX_RLD_LO, 8'ha5);
      // Compare request gating, mask and sticky status
      wr(`ART_IDX_EVT_MASK, 8'h07, OK);
      @(posedge mclk) cmp_flags <= 4'h4;
      repeat (3) @(posedge mclk);
      `CHK("irq_cmp", 1'b1, irq_cmp)
      `CHK("irq", 1'b1, irq)
      wr(`ART_IDX_EVT_MASK, 8'h00, OK);
      repeat (2) @(posedge mclk);
      `CHK("irq", 1'b0, irq)
      wr(`ART_IDX_EVT_MASK, 8'h07, OK);
      wr(`ART_IDX_CSR, 8'h00, OK);
      repeat (2) @(posedge mclk);
      `CHK("irq_cmp", 1'b0, irq_cmp)
      `CHK("irq", 1'b1, irq)
      rx(`ART_IDX_EVT_STAT, 8'h04);
      wr(`ART_IDX_EVT_STAT, 8'h04, OK);
      rx(`ART_IDX_EVT_STAT, 8'h00);
      `CHK("irq", 1'b0, irq)
      @(posedge mclk) cmp_flags <= 4'h0;
      // Count rate of clock select codes 01, 10 and 11 over 200 cycles
      for (int i = 1; i < 4; i++) begin
         rd_cnt(c0);
         wr(`ART_IDX_CSR, 8'(i << 3), OK);
         repeat (200) @(posedge mclk);
         wr(`ART_IDX_CSR, 8'h00, OK);
         rd_cnt(c1);
         dlt = int'(c1 - c0);
         t = (i == 1) ? 10 : (i == 2) ? 40 : 160;
         `CHK("rate", 1'b1, dlt >= t - 1 && dlt <= t + t / 16 + 3)
      end
      // Wrap into a non-zero reload value
      wr(`ART_IDX_RLD_HI, 8'h0f, OK);
      wr(`ART_IDX_RLD_LO, 8'hfa, OK);
      wr(`ART_IDX_CSR, 8'h1a, OK);
      t = 0;
      while (irq_wrap !== 1'b1 && t < 6000) begin
         @(posedge mclk);
         t++;
      end
      `CHK("irq_wrap", 1'b1, irq_wrap)
      wr(`ART_IDX_CSR, 8'h02, OK);
      rd_cnt(c0);
      `CHK("reload", 1'b1, c0 >= 12'hffa)
      rx(`ART_IDX_CSR, 8'h06);
      rx(`ART_IDX_CSR, 8'h02);
      repeat (3) @(posedge mclk);
      `CHK("irq_wrap", 1'b0, irq_wrap)
      rx(`ART_IDX_EVT_STAT, 8'h02);
      wr(`ART_IDX_EVT_STAT, 8'h02, OK);
      // Capture, ignored second edge, clear by read
      wr(`ART_IDX_RLD_HI, 8'h00, OK);
      wr(`ART_IDX_RLD_LO, 8'h00, OK);
      wr(`ART_IDX_CSR, 8'h20, OK);
      @(posedge mclk) pin <= 1'b1;
      repeat (6) @(posedge mclk);
      `CHK("irq_cap", 1'b1, irq_cap)
      rx(`ART_IDX_CSR, 8'h60);
      wr(`ART_IDX_CSR, 8'h38, OK);
      repeat (20) @(posedge mclk);
      pin <= 1'b0;
      repeat (6) @(posedge mclk);
      wr(`ART_IDX_CSR, 8'h20, OK);
      rd_cnt(c1);
      `CHK("moved", 1'b1, c1 != c0)
      rx(`ART_IDX_CAP_LO, c0[7:0]);
      rx(`ART_IDX_CAP_HI, {4'h0, c0[11:8]});
      rx(`ART_IDX_CSR, 8'h24);
      wr(`ART_IDX_CSR, 8'h60, OK);
      rx(`ART_IDX_CSR, 8'h20);
      `CHK("irq_cap", 1'b0, irq_cap)
      @(posedge mclk) pin <= 1'b1;
      repeat (6) @(posedge mclk);
      rx(`ART_IDX_CAP_HI, {4'h0, c1[11:8]});
      rx(`ART_IDX_CAP_LO, c1[7:0]);
      repeat (10) @(posedge mclk);
      rx(`ART_IDX_CSR, 8'h20);
      @(posedge mclk) pin <= 1'b0;
      repeat (6) @(posedge mclk);
      rx(`ART_IDX_CSR, 8'h60);
      close_out();
   end
endmodule // art_timer_tb_top
